//--- core/qei_top.sv
// Quadrature encoder integration: clock gates, input paths, decode, trip and APB registers
//
// Notes on behaviour
// - During system reset both encoder modules are clocked whatever the enable bits.
// - After reset release each module's enable bit decides whether it is clocked.
// - Both clock-enable bits reset to one, at bits 16 and 24.
// - Clearing one enable bit stops only that module.
// - Outside external-clock counting, a module flags phase error when both phase inputs change together.
// - A multiplexer picks either module's phase error for the trip path.
// - The picked error is inverted onto the active-low trip input of every PWM.
// - Each input has a 3-bit selector; 001 synchronised, 010 synchronised and filtered.
// - Selectors for A, B, index, strobe sit at 18:16, 26:24, 2:0, 10:8.
// - The filter passes a level only after six stable clock cycles.
// - In external-clock counting on the synchronised path (001) the counter steps within four cycles of the edge; the filtered path takes ten.
// - On the synchronised path (001) the compare sync output follows its causing input edge within six cycles; the filtered path takes ten.
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module qei_top
  import qei_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_nrst,
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [31:0]           i_paddr,
  input  wire logic [31:0]           i_pwdata,
  output logic      [31:0]           o_prdata,
  output logic                       o_pready,
  output logic                       o_pslverr,
  input  wire qei_pins_t [MOD_N-1:0] i_pins,
  output qei_pins_t      [MOD_N-1:0] o_qei_in,
  output logic      [MOD_N-1:0]      o_clk_en,
  output logic      [MOD_N-1:0]      o_phase_error,
  output logic      [MOD_N-1:0]      o_cmp_sync,
  output logic                       o_trip_zone_four_low,
  output logic                       o_irq
);
  logic             rst_meta;
  logic             rst_n;
  logic [PIN_N-1:0] pin_sync;
  logic [PIN_N-1:0] pin_filt;

  logic [MOD_N-1:0] en_bits, next_en;
  logic [2:0]       sel [PIN_N];
  logic [2:0]       next_sel [PIN_N];
  logic [MOD_N-1:0] ext_mode, next_ext;
  logic             err_sel, next_err_sel;
  qei_evt_t         stat, next_stat, mask, next_mask;
  logic [CNT_W-1:0] cmpv [MOD_N];
  logic [CNT_W-1:0] next_cmpv [MOD_N];
  logic [CNT_W-1:0] cnt [MOD_N];
  logic [CNT_W-1:0] next_cnt [MOD_N];
  qei_pins_t [MOD_N-1:0] prev, next_in;
  logic [MOD_N-1:0] next_perr, next_cmp_sync, next_clk_en;
  logic             next_trip, next_irq;
  logic [31:0]      next_prdata;
  logic             next_pready, next_pslverr;
  logic             wr, setup;
  logic [7:0]       ofs;

  // Reset release through two flip-flops
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Pin synchronisers and filters
  qei_filt u_filt (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_raw   (i_pins),
    .o_sync  (pin_sync),
    .o_filt  (pin_filt)
  );

  // Decode of the offset presented on the bus
  function automatic logic is_mapped(input logic [31:0] a);
    is_mapped = (a[31:8] == 24'h0) && (a[1:0] == 2'h0) && (a[7:0] <= OFS_CNT);
  endfunction

  // Path chosen by one selector code
  function automatic logic pick(input logic [2:0] code, input logic s, input logic f);
    unique case (code)
      SEL_FILT: pick = f;
      SEL_SYNC: pick = s;
      default:  pick = s;
    endcase
  endfunction

  assign ofs   = i_paddr[7:0];
  assign setup = i_psel && !i_penable;
  assign wr    = i_psel && i_penable && o_pready && i_pwrite && !o_pslverr;

  // Register writes and read data, answered in the first access cycle
  always_comb begin
    next_en      = en_bits;
    next_ext     = ext_mode;
    next_err_sel = err_sel;
    next_mask    = mask;
    next_sel     = sel;
    next_cmpv    = cmpv;
    next_prdata  = 32'h0;
    next_pready  = setup;
    next_pslverr = setup && !is_mapped(i_paddr);
    if (wr) begin
      unique case (ofs)
        OFS_PM40: begin
          next_en = {i_pwdata[CLKEN_POS1], i_pwdata[CLKEN_POS0]};
        end
        OFS_MASK: next_mask = qei_evt_t'(i_pwdata[3:0]);
        OFS_MODE: begin
          next_ext     = i_pwdata[MODE_EXT0+:MOD_N];
          next_err_sel = i_pwdata[MODE_ERRSEL];
        end
        OFS_CMP: begin
          next_cmpv[0] = i_pwdata[CNT_W-1:0];
          next_cmpv[1] = i_pwdata[2*CNT_W-1:CNT_W];
        end
        default: ;
      endcase
      for (int i = 0; i < PIN_N; i++) begin
        if (fld_ofs(i) == ofs) begin
          next_sel[i] = i_pwdata[fld_pos(i)+:3];
        end
      end
    end
    if (setup && !i_pwrite && is_mapped(i_paddr)) begin
      unique case (ofs)
        OFS_PM40: begin
          next_prdata[CLKEN_POS0] = en_bits[0];
          next_prdata[CLKEN_POS1] = en_bits[1];
        end
        OFS_STAT: next_prdata[3:0] = stat;
        OFS_MASK: next_prdata[3:0] = mask;
        OFS_MODE: begin
          next_prdata[MODE_EXT0+:MOD_N] = ext_mode;
          next_prdata[MODE_ERRSEL]      = err_sel;
        end
        OFS_CMP:  next_prdata = {cmpv[1], cmpv[0]};
        OFS_CNT:  next_prdata = {cnt[1], cnt[0]};
        default: ;
      endcase
      for (int i = 0; i < PIN_N; i++) begin
        if (fld_ofs(i) == ofs) begin
          next_prdata[fld_pos(i)+:3] = sel[i];
        end
      end
    end
  end

  // Input selection, decode, counting, compare, trip and interrupt
  always_comb begin
    next_stat = stat;
    next_cnt  = cnt;
    for (int i = 0; i < PIN_N; i++) begin
      next_in[i/4][i%4] = pick(sel[i], pin_sync[i], pin_filt[i]);
    end
    next_clk_en = rst_n ? en_bits : CLKEN_RST;
    for (int m = 0; m < MOD_N; m++) begin
      next_perr[m]     = 1'b0;
      next_cmp_sync[m] = 1'b0;
      if (o_clk_en[m]) begin
        if (ext_mode[m]) begin
          if (o_qei_in[m].a && !prev[m].a) begin
            next_cnt[m] = o_qei_in[m].b ? cnt[m] + 16'h1 : cnt[m] - 16'h1;
          end
        end else if ((o_qei_in[m].a ^ prev[m].a) && (o_qei_in[m].b ^ prev[m].b)) begin
          next_perr[m] = 1'b1;
        end else if ((o_qei_in[m].a ^ prev[m].a) || (o_qei_in[m].b ^ prev[m].b)) begin
          next_cnt[m] = (o_qei_in[m].a ^ prev[m].b) ? cnt[m] + 16'h1 : cnt[m] - 16'h1;
        end
        next_cmp_sync[m] = (next_cnt[m] != cnt[m]) && (next_cnt[m] == cmpv[m]);
      end
    end
    next_trip = !(err_sel ? next_perr[1] : next_perr[0]);
    if (wr && ofs == OFS_STAT) begin
      next_stat = stat & ~qei_evt_t'(i_pwdata[3:0]);
    end
    next_stat = next_stat | {next_cmp_sync, next_perr}; // Set wins over clear
    next_irq  = |(next_stat & mask);
  end

  // Register state
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_bits   <= CLKEN_RST;
      ext_mode  <= '0;
      err_sel   <= 1'b0;
      mask      <= '0;
      stat      <= '0;
      o_prdata  <= 32'h0;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      for (int i = 0; i < PIN_N; i++) sel[i] <= SEL_RST;
      for (int m = 0; m < MOD_N; m++) cmpv[m] <= '0;
    end else begin
      en_bits   <= next_en;
      ext_mode  <= next_ext;
      err_sel   <= next_err_sel;
      mask      <= next_mask;
      stat      <= next_stat;
      o_prdata  <= next_prdata;
      o_pready  <= next_pready;
      o_pslverr <= next_pslverr;
      sel       <= next_sel;
      cmpv      <= next_cmpv;
    end
  end

  // Encoder datapath state
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_clk_en             <= CLKEN_RST;
      o_qei_in             <= '0;
      prev                 <= '0;
      o_phase_error        <= '0;
      o_cmp_sync           <= '0;
      o_trip_zone_four_low <= 1'b1;
      o_irq                <= 1'b0;
      for (int m = 0; m < MOD_N; m++) cnt[m] <= '0;
    end else begin
      o_clk_en             <= next_clk_en;
      o_qei_in             <= next_in;
      prev                 <= o_qei_in;
      o_phase_error        <= next_perr;
      o_cmp_sync           <= next_cmp_sync;
      o_trip_zone_four_low <= next_trip;
      o_irq                <= next_irq;
      cnt                  <= next_cnt;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  reset_clock_a: assert property (@(posedge i_clk) disable iff (1'b0)
    !rst_n |=> o_clk_en == CLKEN_RST)
    else $error("module clock not forced on during reset");
  gate_follow_a: assert property (rst_n && $past(rst_n) |->
    o_clk_en == $past(en_bits))
    else $error("clock enable does not follow its bit");
  enable_reset_a: assert property ($rose(rst_n) |-> en_bits == 2'h3)
    else $error("clock enable bits not one after reset");
  gate_alone_a: assert property (!o_clk_en[0] && o_clk_en[1] |=>
    cnt[0] == $past(cnt[0]))
    else $error("gated module still counts");
  phase_err_a: assert property (o_clk_en[0] && !ext_mode[0] &&
    (o_qei_in[0].a != prev[0].a) && (o_qei_in[0].b != prev[0].b) |=> o_phase_error[0])
    else $error("phase error not flagged");
  trip_inv_a: assert property (o_trip_zone_four_low ==
    !($past(err_sel) ? o_phase_error[1] : o_phase_error[0]))
    else $error("trip input not inverted selected error");
  field_map_a: assert property (wr && ofs == OFS_PM44 |=>
    sel[0] == $past(i_pwdata[18:16]) && sel[1] == $past(i_pwdata[26:24]))
    else $error("selector field misplaced");
  path_sel_a: assert property (##1 o_qei_in[0].a == ($past(sel[0]) == SEL_FILT ?
    $past(pin_filt[0]) : $past(pin_sync[0])))
    else $error("wrong input path for phase A");
  filt_qual_a: assert property ($changed(pin_filt[0]) |->
    $past(pin_sync[0], 1) == pin_filt[0] && $past(pin_sync[0], 6) == pin_filt[0])
    else $error("filter passed an unqualified level");
  ext_count_a: assert property (o_clk_en[0] && ext_mode[0] &&
    o_qei_in[0].a && !prev[0].a && o_qei_in[0].b |=> cnt[0] == $past(cnt[0]) + 16'h1)
    else $error("external clock did not step counter");
  cmp_sync_a: assert property (o_cmp_sync[0] |->
    cnt[0] == cmpv[0] && cnt[0] != $past(cnt[0]))
    else $error("compare sync without match");
  two_stage_a: assert property ($past(rst_n) && $past(rst_n, 2) |->
    pin_sync == $past(i_pins, 2))
    else $error("pin not delayed two stages");

  // Second module, undefined selector codes, unselected trip source and sticky status
  default_path_a: assert property (sel[1] != SEL_FILT |=>
    o_qei_in[0].b == $past(pin_sync[1]))
    else $error("undefined selector code left the synchronised path");
  err_mux_a: assert property (o_phase_error[0] && !o_phase_error[1] && $past(err_sel) |->
    o_trip_zone_four_low)
    else $error("unselected module error reached the trip input");
  gate_second_a: assert property (!o_clk_en[1] |=>
    cnt[1] == $past(cnt[1]))
    else $error("gated second module still counts");
  phase_err_second_a: assert property (o_clk_en[1] && !ext_mode[1] &&
    (o_qei_in[1].a != prev[1].a) && (o_qei_in[1].b != prev[1].b) |=> o_phase_error[1])
    else $error("second module phase error not flagged");
  err_sticky_a: assert property (o_phase_error[0] |->
    stat.err[0])
    else $error("phase error not held in status");
  filt_second_a: assert property ($changed(pin_filt[1]) |->
    $past(pin_sync[1], 6) == pin_filt[1])
    else $error("filter passed an unqualified level on phase B");
  cmp_second_a: assert property (o_cmp_sync[1] |->
    cnt[1] == cmpv[1])
    else $error("second module compare sync without match");
endmodule // qei_top
`default_nettype wire

//--- core/qei_pkg.sv
// Shared constants, types and helpers for the quadrature encoder integration block
package qei_pkg;
  // Structure sizes
  localparam int MOD_N = 2;
  localparam int PIN_N = 8;
  localparam int CNT_W = 16;

  // Register byte offsets on the APB slave
  localparam logic [7:0] OFS_PM40 = 8'h00;
  localparam logic [7:0] OFS_PM44 = 8'h04;
  localparam logic [7:0] OFS_PM45 = 8'h08;
  localparam logic [7:0] OFS_PM46 = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_MODE = 8'h18;
  localparam logic [7:0] OFS_CMP  = 8'h1c;
  localparam logic [7:0] OFS_CNT  = 8'h20;

  // Clock-enable field positions and reset value
  localparam int         CLKEN_POS0 = 16;
  localparam int         CLKEN_POS1 = 24;
  localparam logic [1:0] CLKEN_RST  = 2'h3;

  // Input path selector codes
  localparam logic [2:0] SEL_SYNC = 3'h1;
  localparam logic [2:0] SEL_FILT = 3'h2;
  localparam logic [2:0] SEL_RST  = 3'h1;
  localparam int         FLD_BASE = 2;
  localparam int         FLD_STEP = 8;

  // Mode register fields
  localparam int MODE_EXT0   = 0;
  localparam int MODE_ERRSEL = 8;

  // Timing
  localparam int         CLK_NS    = 8;
  localparam int         FILT_CYC  = 6;
  localparam logic [2:0] FILT_LAST = 3'(FILT_CYC - 1);

  // Inputs of one encoder module
  typedef struct packed {
    logic strb;
    logic idx;
    logic b;
    logic a;
  } qei_pins_t;

  // Event layout shared by status and mask
  typedef struct packed {
    logic [1:0] cmp;
    logic [1:0] err;
  } qei_evt_t;

  // Byte offset of the register holding selector i
  function automatic logic [7:0] fld_ofs(input int i);
    fld_ofs = OFS_PM44 + 8'(((i + FLD_BASE) / 4) * 4);
  endfunction

  // Bit position of selector i inside its register
  function automatic int fld_pos(input int i);
    fld_pos = ((i + FLD_BASE) % 4) * FLD_STEP;
  endfunction
endpackage

//--- core/qei_filt.sv
// Double synchroniser and qualification filter for every encoder pin
`timescale 1ns/1ps
`default_nettype none
module qei_filt
  import qei_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic [PIN_N-1:0] i_raw,
  output logic      [PIN_N-1:0] o_sync,
  output logic      [PIN_N-1:0] o_filt
);
  logic [PIN_N-1:0] meta;
  logic [2:0]       cnt      [PIN_N];
  logic [2:0]       next_cnt [PIN_N];
  logic [PIN_N-1:0] next_filt;

  // A level passes only after it has differed from the output for the full width
  always_comb begin
    next_filt = o_filt;
    for (int i = 0; i < PIN_N; i++) begin
      next_cnt[i] = 3'h0;
      if (o_sync[i] != o_filt[i]) begin
        if (cnt[i] == FILT_LAST) begin
          next_filt[i] = o_sync[i];
        end else begin
          next_cnt[i] = cnt[i] + 3'h1;
        end
      end
    end
  end

  // Two stages, then filter state
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta   <= '0;
      o_sync <= '0;
      o_filt <= '0;
      for (int i = 0; i < PIN_N; i++) cnt[i] <= 3'h0;
    end else begin
      meta   <= i_raw;
      o_sync <= meta;
      o_filt <= next_filt;
      for (int i = 0; i < PIN_N; i++) cnt[i] <= next_cnt[i];
    end
  end
endmodule // qei_filt
`default_nettype wire

//--- sim/qei_enc_model.sv
// Behavioural incremental encoder driving the sensor pins of both modules
`timescale 1ns/1ps
`default_nettype none
module qei_enc_model
  import qei_pkg::*;
(
  input  wire logic             i_clk,
  output qei_pins_t [MOD_N-1:0] o_pins
);
  initial o_pins = '0;

  // Set both phase levels, then hold them past sync plus filter width
  task automatic drive(input int m, input logic a, input logic b);
    o_pins[m].a <= a;
    o_pins[m].b <= b;
    repeat (12) @(posedge i_clk);
  endtask

  // Flip phase A for n cycles only, then hold the old level again
  task automatic glitch(input int m, input int n);
    o_pins[m].a <= ~o_pins[m].a;
    repeat (n) @(posedge i_clk);
    o_pins[m].a <= ~o_pins[m].a;
    repeat (12) @(posedge i_clk);
  endtask
endmodule // qei_enc_model
`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for the quadrature encoder integration block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import qei_pkg::*;
  typedef struct {
    logic        wr;
    logic [7:0]  a;
    logic [31:0] d;
    logic        err;
  } qei_row_t;
  logic                  i_clk = 1'h0;
  logic                  i_nrst = 1'h0;
  logic                  psel = 1'h0;
  logic                  penable = 1'h0;
  logic                  pwrite = 1'h0;
  logic [31:0]           paddr = 32'h0;
  logic [31:0]           pwdata = 32'h0;
  logic [31:0]           prdata, rd;
  logic                  pready, pslverr, er, trip, irq;
  logic                  trip_seen = 1'h0;
  logic                  clr = 1'h0;
  logic [MOD_N-1:0]      clk_en, perr, cmp;
  logic [MOD_N-1:0]      err_seen = 2'h0;
  qei_pins_t [MOD_N-1:0] pins, pins_q, qin, qin_q;
  int                    n_errors = 0;
  int                    total_checks = 0;
  int                    age = 0;
  int                    in_age = 99;
  int                    cmp_age = 99;
  qei_row_t              rows [9] = '{
    '{1'h0, OFS_PM40, 32'h01010000, 1'h0},
    '{1'h0, OFS_PM44, 32'h01010000, 1'h0},
    '{1'h0, OFS_PM45, 32'h01010101, 1'h0},
    '{1'h0, OFS_PM46, 32'h00000101, 1'h0},
    '{1'h0, OFS_MASK, 32'h00000000, 1'h0},
    '{1'h1, OFS_MASK, 32'h0000000f, 1'h0},
    '{1'h1, OFS_CMP,  32'h00020001, 1'h0},
    '{1'h0, OFS_CMP,  32'h00020001, 1'h0},
    '{1'h0, 8'h24,    32'h00000000, 1'h1}
  };

  always #(CLK_NS / 2) i_clk = ~i_clk;

  qei_top u_qei_top (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_pins(pins), .o_qei_in(qin),
    .o_clk_en(clk_en), .o_phase_error(perr), .o_cmp_sync(cmp),
    .o_trip_zone_four_low(trip), .o_irq(irq));

  qei_enc_model u_qei_enc_model (.i_clk(i_clk), .o_pins(pins));

  // Latency since the last pin change, and sticky event flags
  always @(posedge i_clk) begin
    pins_q    <= pins;
    qin_q     <= qin;
    age       <= (pins !== pins_q) ? 1 : age + 1;
    in_age    <= clr ? 99 : (qin !== qin_q) ? age : in_age;
    cmp_age   <= clr ? 99 : (|cmp) ? age : cmp_age;
    err_seen  <= clr ? 2'h0 : err_seen | perr;
    trip_seen <= !clr && (trip_seen || !trip);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish(input logic timed_out);
    if (timed_out) n_errors++;
    if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    psel   <= 1'h1;
    pwrite <= wr;
    paddr  <= {24'h0, a};
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'h1;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) tally_and_finish(1'h1);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string w);
    apb(1'h0, a, 32'h0);
    check(rd, e, w);
  endtask

  // Clear the sticky flags at the next rising edge
  task automatic clr_seen();
    clr <= 1'h1;
    @(posedge i_clk);
    clr <= 1'h0;
  endtask

  // One quadrature step up or down on module m
  task automatic step(input int m, input logic up);
    u_qei_enc_model.drive(m, up ? ~pins[m].b : pins[m].b, up ? pins[m].a : ~pins[m].a);
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge i_clk);
    check(clk_en, 2'h3, "enable in reset");
    check(trip, 1'h1, "trip idle");
    i_nrst <= 1'h1;
    repeat (3) @(posedge i_clk);
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) check(rd, rows[i].d, "read data");
      check(er, rows[i].err, "slave error");
    end
    // Counting onto the compare value through the synchronised path
    clr_seen();
    step(0, 1'h1);
    check(cmp_age <= 6, 1'h1, "compare latency");
    check(in_age, 3, "sync latency");
    repeat (4) step(0, 1'h1);
    step(0, 1'h0);
    rdchk(OFS_CNT, 32'h00000004, "count");
    // Phase error, trip and interrupt
    clr_seen();
    u_qei_enc_model.drive(0, ~pins[0].a, ~pins[0].b);
    check(err_seen, 2'h1, "phase error");
    check(trip_seen, 1'h1, "trip from module 0");
    rdchk(OFS_STAT, 32'h5, "status");
    check(irq, 1'h1, "irq raised");
    apb(1'h1, OFS_STAT, 32'h5);
    rdchk(OFS_STAT, 32'h0, "status cleared");
    check(irq, 1'h0, "irq cleared");
    // Select module 1 for the trip path, mask module 0's event
    apb(1'h1, OFS_MODE, 32'h100);
    apb(1'h1, OFS_MASK, 32'he);
    clr_seen();
    u_qei_enc_model.drive(0, ~pins[0].a, ~pins[0].b);
    check(err_seen, 2'h1, "module 0 error");
    check(trip_seen, 1'h0, "unselected no trip");
    check(irq, 1'h0, "irq masked");
    u_qei_enc_model.drive(1, ~pins[1].a, ~pins[1].b);
    check(trip_seen, 1'h1, "trip from module 1");
    rdchk(OFS_STAT, 32'h3, "status both");
    check(irq, 1'h1, "irq unmasked");
    apb(1'h1, OFS_STAT, 32'h3);
    // External clock counting on module 0
    apb(1'h1, OFS_MODE, 32'h101);
    apb(1'h1, OFS_CMP, 32'h00020005);
    u_qei_enc_model.drive(0, 1'h0, 1'h1);
    clr_seen();
    u_qei_enc_model.drive(0, 1'h1, 1'h1);
    check(cmp_age <= 4, 1'h1, "external step latency");
    rdchk(OFS_CNT, 32'h00000005, "external count");
    // Gate module 0 only
    apb(1'h1, OFS_PM40, 32'h01000000);
    repeat (2) @(posedge i_clk);
    check(clk_en, 2'h2, "enable after write");
    u_qei_enc_model.drive(0, 1'h0, 1'h1);
    u_qei_enc_model.drive(0, 1'h1, 1'h1);
    step(1, 1'h1);
    rdchk(OFS_CNT, 32'h00010005, "gated count");
    // Filtered phase A, undefined code on phase B
    apb(1'h1, OFS_PM40, 32'h01010000);
    apb(1'h1, OFS_PM44, 32'h07020000);
    clr_seen();
    u_qei_enc_model.glitch(0, 5);
    check(in_age, 99, "short pulse dropped");
    u_qei_enc_model.drive(0, ~pins[0].a, pins[0].b);
    check(in_age, 3 + FILT_CYC, "filter delay");
    check(qin[0].a, pins[0].a, "filtered level");
    clr_seen();
    u_qei_enc_model.drive(0, pins[0].a, ~pins[0].b);
    check(in_age, 3, "default path");
    // Reset in mid-run clocks both modules again
    apb(1'h1, OFS_PM40, 32'h0);
    repeat (2) @(posedge i_clk);
    check(clk_en, 2'h0, "both gated");
    i_nrst <= 1'h0;
    repeat (2) @(posedge i_clk);
    check(clk_en, 2'h3, "enable in second reset");
    i_nrst <= 1'h1;
    repeat (3) @(posedge i_clk);
    rdchk(OFS_PM40, 32'h01010000, "enable reset value");
    tally_and_finish(1'h0);
  end
endmodule // tb
`default_nettype wire
